// File: hw/ckg_regs.sv
// ckg_regs: serial-port (two-wire) configuration register bank of a clock generator
// assumes scl, sda and register_update come from outside mclk's domain; sda is open drain
// Notes on behaviour
// - writing one to setup bit 5 returns internal registers to defaults
// - soft reset bit clears itself on the next serial clock after the write
// - register 002 reads the silicon revision; writes are ignored
// - register 003 reads a fixed variant code distinguishing family members
// - bit 0 of 004 picks readback: zero buffered copies, one active registers
// - 16-bit user version tag at 005/006, default zero, no effect on behaviour
// - bit 7 of 010 sets phase detector sense, zero positive by default
// - bit-order setting at setup bit 6 is ignored on this port
`timescale 1ns/1ps
`include "ckg_consts.svh"
module ckg_regs (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic scl,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   input wire logic register_update,
   output logic phase_detector_sense,
   output logic [2:0] pump_current_select
);
   logic scl_s1_r, scl_s2_r, scl_d_r;
   logic sda_s1_r, sda_s2_r, sda_d_r;
   logic upd_s1_r, upd_s2_r, upd_d_r;
   logic scl_rise, scl_fall, start_det, stop_det, upd_rise;
   ckg_pkg::ckg_phase_t phase_r;
   logic [3:0] bitcnt_r;
   logic ack_slot_r;
   logic [7:0] rx_r;
   logic [7:0] tx_r;
   logic [15:0] addr_r;
   logic wr_stb_r;
   logic [15:0] wr_addr_r;
   logic [7:0] wr_data_r;
   logic [7:0] setup_r;
   logic [7:0] rdbk_r;
   logic [7:0] tag_lo_buf_r, tag_hi_buf_r, pll1_buf_r;
   logic [7:0] tag_lo_act_r, tag_hi_act_r, pll1_act_r;
   logic sreset_pend_r;
   logic [7:0] rd_word;

   // two flops before any logic looks at a pin
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         scl_d_r <= 1'b1;
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
         sda_d_r <= 1'b1;
         upd_s1_r <= 1'b0;
         upd_s2_r <= 1'b0;
         upd_d_r <= 1'b0;
      end else begin
         scl_s1_r <= scl;
         scl_s2_r <= scl_s1_r;
         scl_d_r <= scl_s2_r;
         sda_s1_r <= sda_i;
         sda_s2_r <= sda_s1_r;
         sda_d_r <= sda_s2_r;
         upd_s1_r <= register_update;
         upd_s2_r <= upd_s1_r;
         upd_d_r <= upd_s2_r;
      end
   end

   assign scl_rise = scl_s2_r & ~scl_d_r;
   assign scl_fall = ~scl_s2_r & scl_d_r;
   assign start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
   assign stop_det = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
   assign upd_rise = upd_s2_r & ~upd_d_r;

   // read mux; buffered copies unless the readback select asks for active ones
   function automatic logic [7:0] rd_mux(input logic [15:0] a, input logic act);
      case (a)
         `CKG_OFS_SETUP: rd_mux = setup_r;
         `CKG_OFS_REVISION: rd_mux = `CKG_REVISION_VAL;
         `CKG_OFS_VARIANT: rd_mux = `CKG_VARIANT_VAL;
         `CKG_OFS_RDBK: rd_mux = rdbk_r;
         `CKG_OFS_TAG_LO: rd_mux = act ? tag_lo_act_r : tag_lo_buf_r;
         `CKG_OFS_TAG_HI: rd_mux = act ? tag_hi_act_r : tag_hi_buf_r;
         `CKG_OFS_PLL1: rd_mux = act ? pll1_act_r : pll1_buf_r;
         default: rd_mux = 8'h00;
      endcase
   endfunction : rd_mux

   // one fetch per read byte; the same word feeds the shifter and its first bit
   assign rd_word = rd_mux(addr_r, rdbk_r[`CKG_BIT_RDBK_ACTIVE]);

   // serial protocol engine: device address, two register address bytes, data bytes.
   // the transfer orientation is always msb first; setup bit 6 is never consulted
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         phase_r <= ckg_pkg::PH_IDLE;
         bitcnt_r <= 4'h0;
         ack_slot_r <= 1'b0;
         rx_r <= 8'h00;
         tx_r <= 8'h00;
         addr_r <= 16'h0000;
         sda_oe_n <= 1'b1;
         wr_stb_r <= 1'b0;
         wr_addr_r <= 16'h0000;
         wr_data_r <= 8'h00;
      end else begin
         wr_stb_r <= 1'b0;
         if (stop_det) begin
            phase_r <= ckg_pkg::PH_IDLE;
            sda_oe_n <= 1'b1;
         end else if (start_det) begin
            phase_r <= ckg_pkg::PH_DEV;
            bitcnt_r <= 4'h0;
            ack_slot_r <= 1'b0;
            sda_oe_n <= 1'b1;
         end else if (phase_r != ckg_pkg::PH_IDLE && scl_rise) begin
            if (bitcnt_r != `CKG_ACK_BIT) begin
               rx_r <= {rx_r[6:0], sda_s2_r};
               bitcnt_r <= bitcnt_r + 4'h1;
            end else if (ack_slot_r && phase_r == ckg_pkg::PH_RDATA && sda_s2_r) begin
               // host refused further data: go quiet until the next start
               phase_r <= ckg_pkg::PH_IDLE;
            end
         end else if (phase_r != ckg_pkg::PH_IDLE && scl_fall) begin
            if (bitcnt_r == `CKG_ACK_BIT && !ack_slot_r) begin
               ack_slot_r <= 1'b1;
               sda_oe_n <= 1'b0;
               case (phase_r)
                  ckg_pkg::PH_DEV: begin
                     if (rx_r[7:1] != `CKG_DEV_ADDR) begin
                        phase_r <= ckg_pkg::PH_IDLE;
                        sda_oe_n <= 1'b1;
                     end else if (rx_r[0]) begin
                        phase_r <= ckg_pkg::PH_RDATA;
                     end else begin
                        phase_r <= ckg_pkg::PH_RA_HI;
                     end
                  end
                  ckg_pkg::PH_RA_HI: begin
                     addr_r[15:8] <= rx_r;
                     phase_r <= ckg_pkg::PH_RA_LO;
                  end
                  ckg_pkg::PH_RA_LO: begin
                     addr_r[7:0] <= rx_r;
                     phase_r <= ckg_pkg::PH_WDATA;
                  end
                  ckg_pkg::PH_WDATA: begin
                     wr_stb_r <= 1'b1;
                     wr_addr_r <= addr_r;
                     wr_data_r <= rx_r;
                     addr_r <= addr_r + 16'h0001;
                  end
                  ckg_pkg::PH_RDATA: sda_oe_n <= 1'b1;
                  default: sda_oe_n <= 1'b1;
               endcase
            end else if (ack_slot_r) begin
               ack_slot_r <= 1'b0;
               bitcnt_r <= 4'h0;
               if (phase_r == ckg_pkg::PH_RDATA) begin
                  tx_r <= rd_word;
                  sda_oe_n <= rd_word[7];
                  addr_r <= addr_r + 16'h0001;
               end else begin
                  sda_oe_n <= 1'b1;
               end
            end else if (phase_r == ckg_pkg::PH_RDATA) begin
               // bitcnt counts bits already clocked out
               sda_oe_n <= (bitcnt_r == `CKG_ACK_BIT) ? 1'b1 : tx_r[3'(7 - bitcnt_r)];
            end
         end
      end
   end

   // the pin is only ever pulled low; the level comes from the enable
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sda_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
      end
   end

   // setup byte and soft reset sequencing; the mirrored nibble is stored as written,
   // the device never repairs a host that breaks the mirror
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         setup_r <= `CKG_RST_SETUP;
         sreset_pend_r <= 1'b0;
      end else if (wr_stb_r && wr_addr_r == `CKG_OFS_SETUP) begin
         setup_r <= wr_data_r;
         sreset_pend_r <= wr_data_r[`CKG_BIT_SOFT_RESET];
      end else if (sreset_pend_r && scl_rise) begin
         setup_r[`CKG_BIT_SOFT_RESET] <= 1'b0;
         sreset_pend_r <= 1'b0;
      end
   end

   // buffered and active copies; soft reset restores both but leaves the setup byte
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rdbk_r <= `CKG_RST_RDBK;
         tag_lo_buf_r <= `CKG_RST_TAG;
         tag_hi_buf_r <= `CKG_RST_TAG;
         pll1_buf_r <= `CKG_RST_PLL1;
         tag_lo_act_r <= `CKG_RST_TAG;
         tag_hi_act_r <= `CKG_RST_TAG;
         pll1_act_r <= `CKG_RST_PLL1;
      end else if (sreset_pend_r && scl_rise) begin
         rdbk_r <= `CKG_RST_RDBK;
         tag_lo_buf_r <= `CKG_RST_TAG;
         tag_hi_buf_r <= `CKG_RST_TAG;
         pll1_buf_r <= `CKG_RST_PLL1;
         tag_lo_act_r <= `CKG_RST_TAG;
         tag_hi_act_r <= `CKG_RST_TAG;
         pll1_act_r <= `CKG_RST_PLL1;
      end else begin
         if (wr_stb_r) begin
            case (wr_addr_r)
               `CKG_OFS_RDBK: rdbk_r <= {7'h00, wr_data_r[`CKG_BIT_RDBK_ACTIVE]};
               `CKG_OFS_TAG_LO: tag_lo_buf_r <= wr_data_r;
               `CKG_OFS_TAG_HI: tag_hi_buf_r <= wr_data_r;
               `CKG_OFS_PLL1: pll1_buf_r <= wr_data_r;
               default: rdbk_r <= rdbk_r;
            endcase
         end
         if (upd_rise) begin
            tag_lo_act_r <= tag_lo_buf_r;
            tag_hi_act_r <= tag_hi_buf_r;
            pll1_act_r <= pll1_buf_r;
         end
      end
   end

   // pll controls follow the active copy only; the tag drives nothing
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         phase_detector_sense <= 1'b0;
         pump_current_select <= 3'h0;
      end else begin
         phase_detector_sense <= pll1_act_r[`CKG_BIT_PD_SENSE];
         pump_current_select <= pll1_act_r[`CKG_PUMP_MSB:`CKG_PUMP_LSB];
      end
   end
endmodule : ckg_regs

// File: hw/ckg_consts.svh
// ckg_consts.svh: offsets, field positions and reset values of the clock generator
// configuration registers; assumes 16-bit register addressing on the serial port
`ifndef CKG_CONSTS_SVH
`define CKG_CONSTS_SVH
`define CKG_OFS_SETUP 16'h0000
`define CKG_OFS_REVISION 16'h0002
`define CKG_OFS_VARIANT 16'h0003
`define CKG_OFS_RDBK 16'h0004
`define CKG_OFS_TAG_LO 16'h0005
`define CKG_OFS_TAG_HI 16'h0006
`define CKG_OFS_PLL1 16'h0010
`define CKG_BIT_SOFT_RESET 5
`define CKG_BIT_BIT_ORDER 6
`define CKG_BIT_RDBK_ACTIVE 0
`define CKG_BIT_PD_SENSE 7
`define CKG_PUMP_MSB 6
`define CKG_PUMP_LSB 4
`define CKG_RST_SETUP 8'h00
`define CKG_RST_RDBK 8'h00
`define CKG_RST_TAG 8'h00
`define CKG_RST_PLL1 8'h7D
// arbitrary neutral values, not taken from any real part
`define CKG_REVISION_VAL 8'h11
`define CKG_VARIANT_VAL 8'h5A
`define CKG_DEV_ADDR 7'h2C
`define CKG_ACK_BIT 4'h8
`endif

// File: hw/ckg_pkg.sv
// ckg_pkg: types shared by the clock generator configuration block
// assumes ckg_consts.svh carries all numeric constants
package ckg_pkg;
   typedef enum logic [2:0] {
      PH_IDLE,
      PH_DEV,
      PH_RA_HI,
      PH_RA_LO,
      PH_WDATA,
      PH_RDATA
   } ckg_phase_t;
endpackage : ckg_pkg

// File: sim/ckg_regs_chk.sv
// ckg_regs_chk: port-level checks of the configuration register bank
// assumes it is bound to ckg_regs and sees only that module's ports
`timescale 1ns/1ps
module ckg_regs_chk (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic scl,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_n,
   input wire logic register_update,
   input wire logic phase_detector_sense,
   input wire logic [2:0] pump_current_select
);
   logic [3:0] quiet_r;
   logic [7:0] low_r;
   // cycles since scl or the update pin last moved; nothing else may move the pll pins
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         quiet_r <= 4'h0;
      end else if ($changed(scl) || $changed(register_update)) begin
         quiet_r <= 4'h0;
      end else if (quiet_r != 4'hF) begin
         quiet_r <= quiet_r + 4'h1;
      end
   end
   // longest legal pull-down is an ack followed by a zero byte
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         low_r <= 8'h00;
      end else if (sda_oe_n) begin
         low_r <= 8'h00;
      end else if (low_r != 8'hFF) begin
         low_r <= low_r + 8'h01;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   sense_dflt_a: assert property ($rose(rstn) |-> ##2 !phase_detector_sense)
      else $error("sense not positive after reset");
   pump_dflt_a: assert property ($rose(rstn) |-> ##2 pump_current_select == 3'h7)
      else $error("pump code not at top after reset");
   pll_quiet_a: assert property (quiet_r > 4'h8 |->
      $stable({phase_detector_sense, pump_current_select})) else $error("pll pins moved");
   oe_high_a: assert property (scl && quiet_r > 4'h1 |-> $stable(sda_oe_n))
      else $error("sda moved while scl high");
   fall_hold_a: assert property ($fell(scl) |-> $stable(sda_oe_n)[*2])
      else $error("sda moved at scl fall");
   drv_low_a: assert property (sda_o == 1'b0)
      else $error("sda driven high");
   hold_limit_a: assert property (low_r < 8'd90)
      else $error("sda held low too long");
   oe_rst_a: assert property ($rose(rstn) |-> sda_oe_n[*3])
      else $error("sda pulled after reset");
endmodule : ckg_regs_chk
bind ckg_regs ckg_regs_chk chk_u (.mclk(mclk), .rstn(rstn), .scl(scl), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe_n(sda_oe_n), .register_update(register_update),
   .phase_detector_sense(phase_detector_sense), .pump_current_select(pump_current_select));

// File: sim/ckg_host.sv
// ckg_host: two-wire host model framing register transfers
// assumes the bench resolves the open-drain wire and returns it as sda_w
`timescale 1ns/1ps
module ckg_host (
   input wire logic mclk,
   input wire logic sda_w,
   output logic scl,
   output logic sda_h
);
   // scl stands high between frames
   initial begin
      scl = 1'b1;
      sda_h = 1'b1;
   end
   task automatic q();
      repeat (2) @(negedge mclk);
   endtask : q
   task automatic start();
      q();
      sda_h = 1'b1;
      q();
      q();
      scl = 1'b1;
      q();
      sda_h = 1'b0;
      q();
      scl = 1'b0;
   endtask : start
   task automatic stop();
      q();
      sda_h = 1'b0;
      q();
      scl = 1'b1;
      q();
      sda_h = 1'b1;
      q();
   endtask : stop
   // data moves only a quarter after scl falls, never on the same edge
   task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r,
      output logic ack);
      logic [8:0] v;
      logic [8:0] s;
      v = {d, last};
      for (int i = 8; i >= 0; i--) begin
         q();
         sda_h = v[i];
         q();
         scl = 1'b1;
         q();
         s[i] = sda_w;
         q();
         scl = 1'b0;
      end
      r = s[8:1];
      ack = s[0];
   endtask : xfer
endmodule : ckg_host

// File: sim/test_clock_gen_i2c_config_regs.sv
// test_clock_gen_i2c_config_regs: register accesses through the host model
// assumes ckg_regs, ckg_host and the bound checker are compiled first
`timescale 1ns/1ps
`include "ckg_consts.svh"
module test_clock_gen_i2c_config_regs;
   logic mclk, rstn, register_update, scl, sda_h, sda_o, sda_oe_n, phase_detector_sense;
   logic [2:0] pump_current_select;
   logic [7:0] rv;
   int num_errors = 0;
   int tests_run = 0;
   wire sda_w = sda_h & (sda_oe_n | sda_o);
   wire [7:0] pins = {4'h0, phase_detector_sense, pump_current_select};
   ckg_regs dut_u (.mclk(mclk), .rstn(rstn), .scl(scl), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe_n(sda_oe_n), .register_update(register_update),
      .phase_detector_sense(phase_detector_sense), .pump_current_select(pump_current_select));
   ckg_host host_u (.mclk(mclk), .sda_w(sda_w), .scl(scl), .sda_h(sda_h));
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      tests_run++;
      if (s !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic head(input logic [15:0] a);
      logic [7:0] r;
      logic k;
      host_u.start();
      host_u.xfer({`CKG_DEV_ADDR, 1'b0}, 1'b1, r, k);
      host_u.xfer(a[15:8], 1'b1, r, k);
      host_u.xfer(a[7:0], 1'b1, r, k);
      chk("address ack", 8'h00, {7'h00, k});
   endtask : head
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      logic [7:0] r;
      logic k;
      head(a);
      host_u.xfer(d, 1'b1, r, k);
      host_u.stop();
      chk("data ack", 8'h00, {7'h00, k});
   endtask : wr
   task automatic rchk(input string n, input logic [15:0] a, input logic [7:0] e);
      logic k;
      head(a);
      host_u.start();
      host_u.xfer({`CKG_DEV_ADDR, 1'b1}, 1'b1, rv, k);
      chk("read address ack", 8'h00, {7'h00, k});
      host_u.xfer(8'hFF, 1'b1, rv, k);
      host_u.stop();
      chk(n, e, rv);
   endtask : rchk
   // the pin is held long enough to survive the input synchroniser
   task automatic upd();
      register_update = 1'b1;
      repeat (8) @(negedge mclk);
      register_update = 1'b0;
      repeat (8) @(negedge mclk);
   endtask : upd
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up
   initial begin
      #2ms;
      num_errors++;
      $display("watchdog expired");
      wrap_up();
   end
   initial begin
      rstn = 1'b0;
      register_update = 1'b0;
      repeat (5) @(negedge mclk);
      rstn = 1'b1;
      repeat (4) @(negedge mclk);
      rchk("readback select", 16'h0004, 8'h00);
      rchk("tag low", 16'h0005, 8'h00);
      rchk("tag high", 16'h0006, 8'h00);
      rchk("pll control", 16'h0010, 8'h7D);
      rchk("unmapped", 16'h0007, 8'h00);
      $display("test defaults done");
      wr(16'h0002, 8'h33);
      wr(16'h0003, 8'h33);
      rchk("revision", 16'h0002, `CKG_REVISION_VAL);
      rchk("variant", 16'h0003, `CKG_VARIANT_VAL);
      wr(16'h0005, 8'hA5);
      wr(16'h0006, 8'h3C);
      upd();
      rchk("tag low", 16'h0005, 8'hA5);
      rchk("tag high", 16'h0006, 8'h3C);
      chk("pll pins", 8'h07, pins);
      $display("test identity and tag done");
      for (int c = 0; c < 8; c++) begin
         wr(16'h0010, {1'b1, c[2:0], 4'hD});
         upd();
         chk("pll pins", {5'h01, c[2:0]}, pins);
      end
      wr(16'h0010, 8'h0D);
      rchk("buffered copy", 16'h0010, 8'h0D);
      wr(16'h0004, 8'h01);
      rchk("active copy", 16'h0010, 8'hFD);
      $display("test pll and readback done");
      wr(16'h0000, 8'h66);
      rchk("setup", 16'h0000, 8'h46);
      rchk("readback select", 16'h0004, 8'h00);
      rchk("tag low", 16'h0005, 8'h00);
      rchk("pll control", 16'h0010, 8'h7D);
      chk("pll pins", 8'h07, pins);
      $display("test soft reset done");
      wrap_up();
   end
endmodule : test_clock_gen_i2c_config_regs
